// ---- hdl/sadc_regs.svh ----
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH

// Register indices; byte address is four times the index
`define SADC_CSR_IDX 10'h070
`define SADC_UPPER_IDX 10'h071
`define SADC_LOWER_IDX 10'h072

// Control/status field positions
`define SADC_EOC_BIT 7
`define SADC_SPEED_BIT 6
`define SADC_ON_BIT 5
`define SADC_RSV_BIT 4
`define SADC_SEL_MSB 3
`define SADC_SEL_LSB 0

// Reset values
`define SADC_CSR_RST 8'h00
`define SADC_RESULT_RST 10'h000

// Converter clock divider: last count of each rate
`define SADC_DIV_FAST_LAST 2'h1
`define SADC_DIV_SLOW_LAST 2'h3

// Successive approximation constants
`define SADC_MSB_IDX 4'h9
`define SADC_MSB_CODE 10'h200

// Bus responses
`define SADC_RESP_OKAY 2'h0
`define SADC_RESP_SLVERR 2'h2

`endif

// ---- hdl/sadc_pkg.sv ----
package sadc_pkg;

   // Control/status register image, bit 7 down to bit 0
   typedef struct packed {
      logic eoc;
      logic speed;
      logic on;
      logic rsv;
      logic [3:0] sel;
   } sadc_csr_t;

   // Signals toward the analog front end
   typedef struct packed {
      logic converter_on;
      logic [3:0] input_select;
      logic sample;
      logic [9:0] trial_code;
   } sadc_fe_t;

   // Register selected by a bus address
   typedef enum logic [1:0] {
      SEL_NONE = 2'h0,
      SEL_CSR = 2'h1,
      SEL_UPPER = 2'h2,
      SEL_LOWER = 2'h3
   } sadc_sel_t;

   // Conversion engine states
   typedef enum logic [2:0] {
      SAR_IDLE = 3'h1,
      SAR_SAMPLE = 3'h2,
      SAR_TRIAL = 3'h4
   } sadc_sar_state_t;

endpackage

// ---- hdl/sadc_sar.sv ----
`timescale 1ns/1ps
`include "sadc_regs.svh"

module sadc_sar
   import sadc_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control from the register block
   input wire logic run,
   input wire logic restart,
   input wire logic tick,
   // Latched comparator decision, synchronous to aclk
   input wire logic cmp_high,
   // Front end drive
   output logic sample,
   output logic [9:0] code,
   // Conversion result
   output logic done,
   output logic [9:0] result
);

   sadc_sar_state_t st_r, st_nxt;
   logic [9:0] code_r, code_nxt;
   logic [3:0] idx_r, idx_nxt;
   logic done_r, done_nxt;
   logic [9:0] result_r, result_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // Next state: one sample tick, then one bit trial per converter tick
   always_comb
   begin
      st_nxt = st_r;
      code_nxt = code_r;
      idx_nxt = idx_r;
      done_nxt = 1'b0;
      result_nxt = result_r;
      if (!run)
      begin
         st_nxt = SAR_IDLE;
         code_nxt = `SADC_RESULT_RST;
      end
      else if (restart)
      begin
         st_nxt = SAR_SAMPLE;
         code_nxt = `SADC_RESULT_RST;
      end
      else
      begin
         case (st_r)
            SAR_IDLE:
               st_nxt = SAR_SAMPLE;
            SAR_SAMPLE:
               if (tick)
               begin
                  st_nxt = SAR_TRIAL;
                  code_nxt = `SADC_MSB_CODE;
                  idx_nxt = `SADC_MSB_IDX;
               end
            SAR_TRIAL:
               if (tick)
               begin
                  // Keep the trial bit only if the input is at or above the code
                  code_nxt[idx_r] = cmp_high;
                  if (idx_r == 4'h0)
                  begin
                     done_nxt = 1'b1;
                     result_nxt = code_nxt;
                     code_nxt = `SADC_RESULT_RST;
                     st_nxt = SAR_SAMPLE;
                  end
                  else
                  begin
                     idx_nxt = idx_r - 4'h1;
                     code_nxt[idx_nxt] = 1'b1;
                  end
               end
            default:
               st_nxt = SAR_IDLE;
         endcase
      end
   end

   // State registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r <= SAR_IDLE;
         code_r <= `SADC_RESULT_RST;
         idx_r <= `SADC_MSB_IDX;
         done_r <= 1'b0;
         result_r <= `SADC_RESULT_RST;
      end
      else
      begin
         st_r <= st_nxt;
         code_r <= code_nxt;
         idx_r <= idx_nxt;
         done_r <= done_nxt;
         result_r <= result_nxt;
      end
   end

   assign sample = (st_r == SAR_SAMPLE);
   assign code = code_r;
   assign done = done_r;
   assign result = result_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking sar_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   trial_count_a: assert property (done_r |-> $past(st_r == SAR_TRIAL && idx_r == 4'h0))
      else $error("done without ten trials");
   keep_going_a: assert property (done_r && run |-> st_r == SAR_SAMPLE)
      else $error("conversion did not restart");
   off_idle_a: assert property (!run |=> st_r == SAR_IDLE && !done_r)
      else $error("engine active while off");
   saturate_c: cover property (done_r && result_r == 10'h3ff);

endmodule // sadc_sar

// ---- hdl/sadc_ctrl.sv ----
// How it works
// - Hardware sets conversion-done flag, bit 7, when a conversion completes.
// - Reading the upper result or writing control/status with byte lane 0 enabled clears the done flag.
// - Rate bit zero divides core clock by four, one divides by two.
// - Converter-on zero stops conversion; setting it starts converting.
// - Four-bit input select is a plain binary input index.
// - Upper result is read-only and shows result bits nine to two.
// - Lower result is read-only, bits one and zero, zeros above.
// - Control/status bits are read/write except the done flag.
// - Reset clears control/status and both result registers.
// - While on, conversions repeat back to back on the selected input.
// - Changing input select aborts, clears done flag, restarts on new input.
// - Input above reference saturates to all ones, no overflow flag.
// - Results are not paired; each completion overwrites both halves.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "sadc_regs.svh"

module sadc_ctrl
   import sadc_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic awvalid,
   output logic awready,
   input wire logic [11:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [11:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Analog front end
   output sadc_fe_t fe,
   input wire logic cmp_high
);

   // Address decode shared by the read and write paths
   function automatic sadc_sel_t reg_decode(input logic [11:0] addr);
      sadc_sel_t sel;
      sel = SEL_NONE;
      if (addr[11:2] == `SADC_CSR_IDX)
         sel = SEL_CSR;
      else if (addr[11:2] == `SADC_UPPER_IDX)
         sel = SEL_UPPER;
      else if (addr[11:2] == `SADC_LOWER_IDX)
         sel = SEL_LOWER;
      return sel;
   endfunction

   logic aw_got_r, aw_got_nxt;
   logic [11:0] aw_addr_r, aw_addr_nxt;
   logic w_got_r, w_got_nxt;
   logic [31:0] w_data_r, w_data_nxt;
   logic w_lane0_r, w_lane0_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   sadc_csr_t csr_r, csr_nxt;
   logic [9:0] result_r, result_nxt;
   logic [1:0] div_r, div_nxt;
   logic wr_commit;
   sadc_sel_t wr_sel;
   sadc_sel_t rd_sel;
   logic ar_fire;
   logic csr_wr;
   logic upper_rd;
   logic ch_change;
   logic tick;
   logic sar_done;
   logic [9:0] sar_result;
   logic sar_sample;
   logic [9:0] sar_code;

   ////////////////////////////////////////////////////////////////////////////
   // Write path: address and data are caught in either order, then committed
   assign awready = !aw_got_r && !bvalid_r;
   assign wready = !w_got_r && !bvalid_r;
   assign wr_commit = aw_got_r && w_got_r;
   assign wr_sel = reg_decode(aw_addr_r);
   // A write with lane 0 off touches no bit, so it leaves the done flag alone
   assign csr_wr = wr_commit && wr_sel == SEL_CSR && w_lane0_r;
   assign ch_change = csr_wr && w_data_r[`SADC_SEL_MSB:`SADC_SEL_LSB] != csr_r.sel;

   always_comb
   begin
      aw_got_nxt = aw_got_r;
      aw_addr_nxt = aw_addr_r;
      w_got_nxt = w_got_r;
      w_data_nxt = w_data_r;
      w_lane0_nxt = w_lane0_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      if (awvalid && awready)
      begin
         aw_got_nxt = 1'b1;
         aw_addr_nxt = awaddr;
      end
      if (wvalid && wready)
      begin
         w_got_nxt = 1'b1;
         w_data_nxt = wdata;
         w_lane0_nxt = wstrb[0];
      end
      if (wr_commit)
      begin
         aw_got_nxt = 1'b0;
         w_got_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         // Read-only targets accept and ignore; holes answer with an error
         bresp_nxt = (wr_sel == SEL_NONE) ? `SADC_RESP_SLVERR : `SADC_RESP_OKAY;
      end
      else if (bvalid_r && bready)
         bvalid_nxt = 1'b0;
   end

   // Write path registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_r <= 1'b0;
         aw_addr_r <= 12'h000;
         w_got_r <= 1'b0;
         w_data_r <= 32'h00000000;
         w_lane0_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= `SADC_RESP_OKAY;
      end
      else
      begin
         aw_got_r <= aw_got_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_got_r <= w_got_nxt;
         w_data_r <= w_data_nxt;
         w_lane0_r <= w_lane0_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
      end
   end

   assign bvalid = bvalid_r;
   assign bresp = bresp_r;

   ////////////////////////////////////////////////////////////////////////////
   // Read path: one read in flight, data captured at the address handshake
   assign arready = !rvalid_r;
   assign ar_fire = arvalid && arready;
   assign rd_sel = reg_decode(araddr);
   assign upper_rd = ar_fire && rd_sel == SEL_UPPER;

   always_comb
   begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (ar_fire)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt = `SADC_RESP_OKAY;
         case (rd_sel)
            SEL_CSR:
               rdata_nxt = {24'h000000, csr_r};
            SEL_UPPER:
               rdata_nxt = {24'h000000, result_r[9:2]};
            SEL_LOWER:
               rdata_nxt = {30'h00000000, result_r[1:0]};
            default:
            begin
               rdata_nxt = 32'h00000000;
               rresp_nxt = `SADC_RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid_r && rready)
         rvalid_nxt = 1'b0;
   end

   // Read path registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= `SADC_RESP_OKAY;
      end
      else
      begin
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;

   ////////////////////////////////////////////////////////////////////////////
   // Control/status and result registers
   always_comb
   begin
      csr_nxt = csr_r;
      result_nxt = result_r;
      if (csr_wr)
      begin
         // Done flag takes no write data
         csr_nxt.speed = w_data_r[`SADC_SPEED_BIT];
         csr_nxt.on = w_data_r[`SADC_ON_BIT];
         csr_nxt.rsv = w_data_r[`SADC_RSV_BIT];
         csr_nxt.sel = w_data_r[`SADC_SEL_MSB:`SADC_SEL_LSB];
      end
      if (upper_rd || csr_wr)
         csr_nxt.eoc = 1'b0;
      // Completion wins over a clear in the same cycle
      if (sar_done)
      begin
         csr_nxt.eoc = 1'b1;
         result_nxt = sar_result;
      end
   end

   // Register file
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         csr_r <= `SADC_CSR_RST;
         result_r <= `SADC_RESULT_RST;
      end
      else
      begin
         csr_r <= csr_nxt;
         result_r <= result_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Converter clock enable; held in reset while off to save power
   assign tick = csr_r.on &&
      div_r == (csr_r.speed ? `SADC_DIV_FAST_LAST : `SADC_DIV_SLOW_LAST);

   always_comb
   begin
      div_nxt = div_r + 2'h1;
      if (!csr_r.on || tick)
         div_nxt = 2'h0;
   end

   // Divider register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         div_r <= 2'h0;
      else
         div_r <= div_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Conversion engine
   sadc_sar u_sar (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(csr_r.on),
      .restart(ch_change),
      .tick(tick),
      .cmp_high(cmp_high),
      .sample(sar_sample),
      .code(sar_code),
      .done(sar_done),
      .result(sar_result)
   );

   // Front end drive from flip-flops, except sample, which is decoded from the engine state
   assign fe.converter_on = csr_r.on;
   assign fe.input_select = csr_r.sel;
   assign fe.sample = sar_sample;
   assign fe.trial_code = sar_code;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking ctrl_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   eoc_set_a: assert property (sar_done |=> csr_r.eoc)
      else $error("done flag not set on completion");
   eoc_read_clear_a: assert property (upper_rd && !sar_done |=> !csr_r.eoc)
      else $error("upper read did not clear done flag");
   eoc_write_clear_a: assert property (csr_wr && !sar_done |=> !csr_r.eoc)
      else $error("control write did not clear done flag");
   fast_rate_a: assert property (tick && csr_r.speed && csr_r.on |=> !tick)
      else $error("fast rate ticks too often");
   slow_rate_a: assert property ((tick && !csr_r.speed) ##1 !csr_r.speed
      |-> !tick ##1 (!tick || csr_r.speed))
      else $error("slow rate ticks too often");
   off_quiet_a: assert property (!csr_r.on |-> !tick ##1 !sar_done)
      else $error("converter active while off");
   sel_restart_a: assert property (ch_change && !sar_done
      |=> !csr_r.eoc && !sar_done ##1 !sar_done)
      else $error("input change did not abort");
   upper_read_a: assert property (upper_rd
      |=> rvalid && rdata == {24'h000000, $past(result_r[9:2])})
      else $error("upper result read wrong");
   lower_read_a: assert property (ar_fire && rd_sel == SEL_LOWER
      |=> rdata[31:2] == 30'h00000000 && rdata[1:0] == $past(result_r[1:0]))
      else $error("lower result read wrong");
   reset_zero_a: assert property ($rose(aresetn)
      |-> csr_r == `SADC_CSR_RST && result_r == `SADC_RESULT_RST)
      else $error("registers not cleared by reset");

   done_then_read_c: cover property (csr_r.eoc ##[1:20] upper_rd);
   sel_abort_c: cover property (ch_change && fe.sample == 1'b0);
   fast_done_c: cover property (csr_r.speed && sar_done);
   unmapped_c: cover property (ar_fire && rd_sel == SEL_NONE);

endmodule // sadc_ctrl

// ---- verification/sadc_fe_model.sv ----
`timescale 1ns/1ps

module sadc_fe_model
   import sadc_pkg::*;
(
   // Clock
   input wire logic aclk,
   // Drive from the converter and analog stimulus
   input wire sadc_fe_t fe,
   input wire logic [15:0][9:0] level,
   input wire logic over,
   // Latched comparator decision
   output logic cmp_high
);

   ////////////////////////////////////////////////////////////////////////////////
   // Comparator latch, clocked by the core clock like the real front end
   initial cmp_high = 1'b0;

   // While off the decision means nothing, so it toggles instead of holding stale data
   always @(posedge aclk)
   begin
      if (!fe.converter_on)
         cmp_high <= !cmp_high;
      else
         cmp_high <= over || (level[fe.input_select] >= fe.trial_code);
   end

endmodule // sadc_fe_model

// ---- verification/sar_adc_control_regs_test.sv ----
`timescale 1ns/1ps
`include "sadc_regs.svh"

module sar_adc_control_regs_test
   import sadc_pkg::*;
;

   typedef struct packed {
      logic [7:0] csr;
      logic [7:0] up;
      logic [7:0] lo;
      logic [3:0] period;
   } sadc_row_t;

   localparam logic [11:0] CSR_A = {`SADC_CSR_IDX, 2'h0};
   localparam logic [11:0] UP_A = {`SADC_UPPER_IDX, 2'h0};
   localparam logic [11:0] LO_A = {`SADC_LOWER_IDX, 2'h0};
   localparam logic [11:0] BAD_A = 12'h1cc;

   ////////////////////////////////////////////////////////////////////////////////
   // Design signals
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [11:0] awaddr = 12'h0;
   logic [11:0] araddr = 12'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic [3:0] strobe = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, cmp_high;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [31:0] d;
   sadc_fe_t fe;
   logic [15:0][9:0] level;
   logic over = 1'b0;
   sadc_row_t rows [4];
   int errors = 0;
   int checked = 0;

   always #5 aclk = ~aclk;

   sadc_ctrl dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .fe(fe), .cmp_high(cmp_high));

   sadc_fe_model front (.aclk(aclk), .fe(fe), .level(level), .over(over),
      .cmp_high(cmp_high));

   ////////////////////////////////////////////////////////////////////////////////
   // Compare tasks
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Bus cycles; handshakes are judged at the falling edge, where inputs are steady
   task automatic bus_write(input logic [11:0] a, input logic [7:0] v, input logic [1:0] er);
      logic ha, hw, hb;
      logic [1:0] r;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, v};
      wstrb <= strobe;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      hb = 1'b0;
      while (!hb)
      begin
         @(negedge aclk);
         ha = awvalid && awready;
         hw = wvalid && wready;
         hb = bvalid;
         r = bresp;
         @(posedge aclk);
         if (ha)
            awvalid <= 1'b0;
         if (hw)
            wvalid <= 1'b0;
      end
      bready <= 1'b0;
      check_resp(r, er);
   endtask

   task automatic bus_read(input logic [11:0] a, output logic [31:0] v, input logic [1:0] er);
      logic ha, hr;
      logic [1:0] r;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      hr = 1'b0;
      while (!hr)
      begin
         @(negedge aclk);
         ha = arvalid && arready;
         hr = rvalid;
         v = rdata;
         r = rresp;
         @(posedge aclk);
         if (ha)
            arvalid <= 1'b0;
      end
      rready <= 1'b0;
      check_resp(r, er);
   endtask

   // Polls the done flag; bounded so a dead converter shows up as a mismatch
   task automatic wait_done();
      logic [31:0] v;
      int n;
      v = 32'h0;
      n = 0;
      while (v[7] !== 1'b1 && n < 60)
      begin
         bus_read(CSR_A, v, 2'h0);
         n++;
      end
      check_val({31'h0, v[7]}, 32'h1);
   endtask

   // Measures converter tick spacing as the gap between first two trial codes
   task automatic tick_period(input logic [3:0] exp);
      int n;
      n = 0;
      while (fe.sample !== 1'b1 && n < 100)
      begin
         @(negedge aclk);
         n++;
      end
      while (fe.sample === 1'b1 && n < 200)
      begin
         @(negedge aclk);
         n++;
      end
      check_val({22'h0, fe.trial_code}, {22'h0, `SADC_MSB_CODE});
      n = 0;
      do
      begin
         @(negedge aclk);
         n++;
      end while (fe.trial_code === `SADC_MSB_CODE && n < 20);
      check_val(32'(n), {28'h0, exp});
   endtask

   task automatic give_verdict();
      $display("Comparisons %0d, errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog: the whole sequence needs a few hundred cycles
   initial
   begin
      repeat (20000) @(posedge aclk);
      errors++;
      give_verdict();
   end

   // Main sequence
   initial
   begin
      for (int c = 0; c < 16; c++)
         level[c] = 10'(c) * 10'h041 + 10'h005;
      rows = '{'{8'h20, 8'h01, 8'h01, 4'h4}, '{8'h65, 8'h52, 8'h02, 4'h2},
         '{8'h2a, 8'ha3, 8'h03, 4'h4}, '{8'h6f, 8'hf5, 8'h00, 4'h2}};
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset state, unmapped place, read-only places
      bus_read(CSR_A, d, 2'h0);
      check_val(d, 32'h0);
      bus_read(UP_A, d, 2'h0);
      check_val(d, 32'h0);
      check_val({17'h0, fe}, 32'h0);
      bus_read(BAD_A, d, 2'h2);
      check_val(d, 32'h0);
      bus_write(BAD_A, 8'h55, 2'h2);
      bus_write(UP_A, 8'hff, 2'h0);
      bus_read(UP_A, d, 2'h0);
      check_val(d, 32'h0);
      bus_write(LO_A, 8'hff, 2'h0);
      bus_read(LO_A, d, 2'h0);
      check_val(d, 32'h0);
      // Done flag ignores writes; nothing converts while off
      bus_write(CSR_A, 8'hc4, 2'h0);
      repeat (50) @(posedge aclk);
      bus_read(CSR_A, d, 2'h0);
      check_val(d, 32'h44);
      check_val({28'h0, fe.input_select}, 32'h4);
      check_val({31'h0, fe.converter_on}, 32'h0);
      // Ordinary conversions: channel, rate and result split
      foreach (rows[i])
      begin
         bus_write(CSR_A, rows[i].csr, 2'h0);
         check_val({28'h0, fe.input_select}, {28'h0, rows[i].csr[3:0]});
         tick_period(rows[i].period);
         wait_done();
         bus_read(LO_A, d, 2'h0);
         check_val(d, {24'h0, rows[i].lo});
         bus_read(UP_A, d, 2'h0);
         check_val(d, {24'h0, rows[i].up});
         bus_read(CSR_A, d, 2'h0);
         check_val(d, {24'h0, rows[i].csr});
      end
      // Conversions repeat unprompted; a same-value write still clears the flag
      wait_done();
      // A write with no byte lane enabled touches no bit, so the flag stays
      strobe = 4'h0;
      bus_write(CSR_A, 8'h00, 2'h0);
      strobe = 4'hf;
      bus_read(CSR_A, d, 2'h0);
      check_val(d, 32'hef);
      bus_write(CSR_A, 8'h6f, 2'h0);
      bus_read(CSR_A, d, 2'h0);
      check_val(d, 32'h6f);
      // Over-range input saturates, with no extra status bit
      over <= 1'b1;
      wait_done();
      bus_read(UP_A, d, 2'h0);
      wait_done();
      bus_read(LO_A, d, 2'h0);
      check_val(d, 32'h3);
      bus_read(UP_A, d, 2'h0);
      check_val(d, 32'hff);
      bus_read(CSR_A, d, 2'h0);
      check_val(d, 32'h6f);
      over <= 1'b0;
      // Channel change with the flag set aborts and restarts
      wait_done();
      bus_write(CSR_A, 8'h20, 2'h0);
      bus_read(CSR_A, d, 2'h0);
      check_val(d, 32'h20);
      wait_done();
      bus_read(LO_A, d, 2'h0);
      check_val(d, 32'h1);
      bus_read(UP_A, d, 2'h0);
      check_val(d, 32'h1);
      // Turning off stops the engine
      bus_write(CSR_A, 8'h00, 2'h0);
      repeat (60) @(posedge aclk);
      bus_read(CSR_A, d, 2'h0);
      check_val(d, 32'h0);
      check_val({21'h0, fe.sample, fe.trial_code}, 32'h0);
      // Reset in mid-run clears everything again
      bus_write(CSR_A, 8'h65, 2'h0);
      wait_done();
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      bus_read(CSR_A, d, 2'h0);
      check_val(d, 32'h0);
      bus_read(LO_A, d, 2'h0);
      check_val(d, 32'h0);
      give_verdict();
   end

endmodule // sar_adc_control_regs_test
